// >>> src/capun_top.sv
// Capture channel with timer select, open-drain pin options, remap strap and interrupt enables.
// Assumes the timer counts arrive on this clock; the capture pin is asynchronous.
// Functional notes
// - On a capture event copy the full 16-bit selected timer count into the pair.
// - Events: each falling, each rising, every fourth or every sixteenth rising edge.
// - The low nibble of the channel control register selects the event type.
// - Each capture sets the channel interrupt flag at bit 1 of the flag register.
// - A new capture overwrites the earlier value even if not yet read.
// - With the pin set as output, a port register write causes a capture.
// - A per-channel field in the timer select register picks the capture timer.
// - Open-drain bits 7 to 2 make a channel's driver open-drain in output modes.
// - Remap bit 1 routes channels six to nine to group A when 1, else B.
// - Enable register bits 7 to 0 enable interrupts of channels ten down to three.
// - On the small-memory variant, enable bits for channels ten and nine are unimplemented.
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "capun_regs.svh"

module capun_top
   import capun_pkg::*;
#(
   parameter bit SMALL_MEM = 1'b0
) (
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic [15:0] timer_one_count,
   input  wire logic [15:0] timer_three_count,
   input  wire logic        cap_pin_in,
   output logic             cap_pin_out,
   output logic             cap_pin_oe,
   input  wire logic        remap_strap,
   output logic             remap_group_a,
   output logic [5:0]       open_drain_select_bits,
   output logic             irq
);
   logic [3:0]  capture_event_select;
   logic [15:0] capture_value_r;
   logic [7:0]  peripheral_flag_reg_four;
   logic [7:0]  capture_channel_irq_enable_hi;
   logic [7:0]  timer_select_regs;
   logic        pin_direction_bit;
   logic        port_latch_r;
   logic        channel_pin_remap_bit;
   logic        strap_taken_r;
   logic        strap_s1_r;
   logic        strap_s2_r;
   logic        sync1_r;
   logic        sync2_r;
   logic        pin_prev_r;
   logic [3:0]  presc_r;
   logic        ack_r;

   // Two-flop synchronisers for the capture pin and the strap; only the second stage of each feeds logic.
   always_ff @(posedge clock) begin
      sync1_r    <= cap_pin_in;
      sync2_r    <= sync1_r;
      strap_s1_r <= remap_strap;
      strap_s2_r <= strap_s1_r;
   end

   wire bus_req  = (avs_read | avs_write) & ~ack_r;
   wire wr_take  = avs_write & ack_r;
   wire sel_ctrl = avs_address == `CAPUN_OFF_CTRL;
   wire sel_flag = avs_address == `CAPUN_OFF_FLAGS;
   wire sel_en   = avs_address == `CAPUN_OFF_IRQ_EN;
   wire sel_tsel = avs_address == `CAPUN_OFF_TMR_SEL;
   wire sel_od   = avs_address == `CAPUN_OFF_OD_CTRL;
   wire sel_port = avs_address == `CAPUN_OFF_PORT;

   // The pin level seen by the edge detector is the driven latch when the pin is an output.
   // That path skips the output register and the synchroniser, so an edge driven by the block is seen three cycles sooner.
   wire       pin_level = pin_direction_bit ? sync2_r : port_latch_r;
   wire       rise      = pin_level & ~pin_prev_r;
   wire       fall      = ~pin_level & pin_prev_r;
   // A port write with the pin as output is a capture condition on its own.
   wire       port_cap  = wr_take & sel_port & ~pin_direction_bit;

   // Codes outside the four capture modes decode to no event, so the pin never captures there.
   function automatic capun_ev_t decode_mode(input logic [3:0] m);
      case (m)
         `CAPUN_M_FALL:   decode_mode = CAPUN_EV_FALL;
         `CAPUN_M_RISE:   decode_mode = CAPUN_EV_RISE;
         `CAPUN_M_RISE4:  decode_mode = CAPUN_EV_PRESC;
         `CAPUN_M_RISE16: decode_mode = CAPUN_EV_PRESC;
         default:         decode_mode = CAPUN_EV_NONE;
      endcase
   endfunction

   wire capun_ev_t ev_kind = decode_mode(capture_event_select);
   wire [3:0] presc_top = (capture_event_select == `CAPUN_M_RISE16) ? `CAPUN_PRESC16_TOP : `CAPUN_PRESC4_TOP;
   logic edge_hit;
   always_comb begin
      case (ev_kind)
         CAPUN_EV_FALL:  edge_hit = fall;
         CAPUN_EV_RISE:  edge_hit = rise;
         CAPUN_EV_PRESC: edge_hit = rise & (presc_r == presc_top);
         default:        edge_hit = 1'b0;
      endcase
   end
   wire cap_evt = edge_hit | port_cap;
   // Timer selection field bit 0 chooses the capture timer.
   wire [15:0] sel_count = timer_select_regs[0] ? timer_three_count : timer_one_count;

   // Enable bits of channels ten and nine stay zero on the small variant and read back as zero.
   wire [7:0] en_mask = SMALL_MEM ? 8'h3F : 8'hFF;
   wire       flag_clr = wr_take & sel_flag & avs_writedata[`CAPUN_FLAG_BIT];

   always_ff @(posedge clock) begin
      if (srst) begin
         pin_prev_r <= 1'b0;
         presc_r    <= 4'h0;
      end else begin
         pin_prev_r <= pin_level;
         // A rewritten mode restarts the count, so a smaller ratio never starts above its top.
         if (ev_kind != CAPUN_EV_PRESC)
            presc_r <= 4'h0;
         else if (wr_take && sel_ctrl)
            presc_r <= 4'h0;
         else if (rise)
            presc_r <= (presc_r == presc_top) ? 4'h0 : presc_r + 4'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst)
         capture_value_r <= 16'h0000;
      else if (cap_evt)
         capture_value_r <= sel_count;
   end

   // Set wins over a same-cycle write-one clear; hardware never clears the flag.
   always_ff @(posedge clock) begin
      if (srst)
         peripheral_flag_reg_four <= 8'h00;
      else if (cap_evt)
         peripheral_flag_reg_four[`CAPUN_FLAG_BIT] <= 1'b1;
      else if (flag_clr)
         peripheral_flag_reg_four[`CAPUN_FLAG_BIT] <= 1'b0;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         capture_event_select          <= `CAPUN_CTRL_RST;
         capture_channel_irq_enable_hi <= `CAPUN_IRQEN_RST;
         timer_select_regs             <= 8'h00;
         open_drain_select_bits        <= `CAPUN_OD_RST;
         pin_direction_bit             <= 1'b1;
         port_latch_r                  <= 1'b0;
      end else if (wr_take) begin
         if (sel_ctrl)
            capture_event_select <= avs_writedata[3:0];
         if (sel_en)
            capture_channel_irq_enable_hi <= avs_writedata[7:0] & en_mask;
         if (sel_tsel)
            timer_select_regs <= avs_writedata[7:0];
         if (sel_od)
            open_drain_select_bits <= avs_writedata[7:2];
         if (sel_port) begin
            port_latch_r      <= avs_writedata[0];
            pin_direction_bit <= avs_writedata[1];
         end
      end
   end

   // The strap is taken once after reset release; later changes of the pin are ignored.
   always_ff @(posedge clock) begin
      if (srst) begin
         strap_taken_r         <= 1'b0;
         channel_pin_remap_bit <= `CAPUN_REMAP_RST;
      end else if (!strap_taken_r) begin
         strap_taken_r         <= 1'b1;
         channel_pin_remap_bit <= strap_s2_r;
      end
   end

   // Open-drain (bit 0 of the select bits is this channel) only drives low.
   wire od_this  = open_drain_select_bits[0];
   wire drive_en = ~pin_direction_bit & (~od_this | ~port_latch_r);

   // Reserved bits and unmapped offsets read as zero.
   logic [31:0] rd_mux;
   always_comb begin
      case (avs_address)
         `CAPUN_OFF_CTRL:     rd_mux = {28'h0, capture_event_select};
         `CAPUN_OFF_CAP_LOW:  rd_mux = {24'h0, capture_value_r[7:0]};
         `CAPUN_OFF_CAP_HIGH: rd_mux = {24'h0, capture_value_r[15:8]};
         `CAPUN_OFF_FLAGS:    rd_mux = {24'h0, peripheral_flag_reg_four};
         `CAPUN_OFF_IRQ_EN:   rd_mux = {24'h0, capture_channel_irq_enable_hi};
         `CAPUN_OFF_TMR_SEL:  rd_mux = {24'h0, timer_select_regs};
         `CAPUN_OFF_OD_CTRL:  rd_mux = {24'h0, open_drain_select_bits, 2'h0};
         `CAPUN_OFF_PORT:     rd_mux = {30'h0, pin_direction_bit, port_latch_r};
         `CAPUN_OFF_PIN_CFG:  rd_mux = {30'h0, channel_pin_remap_bit, strap_taken_r};
         default:             rd_mux = 32'h0;
      endcase
   end

   // Channel four's flag with its enable bit (bit 1) forms the interrupt.
   wire irq_nxt = peripheral_flag_reg_four[`CAPUN_FLAG_BIT] & capture_channel_irq_enable_hi[1];

   // One wait cycle per access keeps the read path registered.
   // A request is answered at the second edge after it rises, so each access takes two cycles.
   always_ff @(posedge clock) begin
      if (srst) begin
         ack_r           <= 1'b0;
         avs_readdata    <= 32'h0;
         avs_waitrequest <= 1'b1;
         cap_pin_out     <= 1'b0;
         cap_pin_oe      <= 1'b0;
         remap_group_a   <= `CAPUN_REMAP_RST;
         irq             <= 1'b0;
      end else begin
         ack_r           <= bus_req;
         avs_readdata    <= rd_mux;
         avs_waitrequest <= ~bus_req;
         cap_pin_out     <= port_latch_r;
         cap_pin_oe      <= drive_en;
         remap_group_a   <= channel_pin_remap_bit;
         irq             <= irq_nxt;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   cap_value_a: assert property (cap_evt |=> capture_value_r == $past(sel_count))
      else $error("capture value not loaded");
   cap_flag_a: assert property (cap_evt |=> peripheral_flag_reg_four[1])
      else $error("capture flag not set");
   flag_hold_a: assert property (peripheral_flag_reg_four[1] && !flag_clr |=> peripheral_flag_reg_four[1])
      else $error("flag cleared without software");
   port_cap_a: assert property (port_cap |=> capture_value_r == $past(sel_count))
      else $error("port write did not capture");
   fall_mode_a: assert property (ev_kind == CAPUN_EV_FALL && rise && !port_cap |-> !cap_evt)
      else $error("rising edge captured in falling mode");
   irq_gate_a: assert property (!capture_channel_irq_enable_hi[1] |=> !irq)
      else $error("irq without enable");
   irq_on_a: assert property (peripheral_flag_reg_four[1] && capture_channel_irq_enable_hi[1] |=> irq)
      else $error("irq missing");
   small_en_a: assert property (SMALL_MEM |-> capture_channel_irq_enable_hi[7:6] == 2'b00)
      else $error("unimplemented enable set");
   od_drive_a: assert property (od_this && port_latch_r |=> !cap_pin_oe)
      else $error("open-drain drove high");
   remap_a: assert property (strap_taken_r |=> remap_group_a == channel_pin_remap_bit)
      else $error("remap output wrong");
   remap_hold_a: assert property (strap_taken_r |=> $stable(channel_pin_remap_bit))
      else $error("remap bit changed after the strap was taken");

   // Event selection and prescaling.
   presc_range_a: assert property (presc_r <= presc_top)
      else $error("prescaler above its top");
   rise_cap_a: assert property (ev_kind == CAPUN_EV_RISE && rise |-> cap_evt)
      else $error("rising edge missed");
   fall_cap_a: assert property (ev_kind == CAPUN_EV_FALL && fall |-> cap_evt)
      else $error("falling edge missed");
   presc_skip_a: assert property (ev_kind == CAPUN_EV_PRESC && rise && presc_r != presc_top
      && !port_cap |-> !cap_evt)
      else $error("prescaled capture before its count");
   presc_hit_a: assert property (ev_kind == CAPUN_EV_PRESC && rise && presc_r == presc_top |-> cap_evt)
      else $error("prescaled capture missed");
   no_pin_cap_a: assert property (ev_kind == CAPUN_EV_NONE && !port_cap |-> !cap_evt)
      else $error("capture in an idle mode");
   cap_hold_a: assert property (!cap_evt |=> $stable(capture_value_r))
      else $error("capture value changed without an event");
   tsel_one_a: assert property (cap_evt && !timer_select_regs[0] |=>
      capture_value_r == $past(timer_one_count))
      else $error("timer one not captured");
   tsel_three_a: assert property (cap_evt && timer_select_regs[0] |=>
      capture_value_r == $past(timer_three_count))
      else $error("timer three not captured");

   // Flag and interrupt.
   flag_clear_a: assert property (flag_clr && !cap_evt |=> !peripheral_flag_reg_four[1])
      else $error("write-one clear lost");
   irq_flag_a: assert property (!peripheral_flag_reg_four[1] |=> !irq)
      else $error("irq without flag");

   // Register writes land at the edge that completes the access.
   mode_write_a: assert property (wr_take && sel_ctrl |=> capture_event_select == $past(avs_writedata[3:0]))
      else $error("mode write lost");
   tsel_write_a: assert property (wr_take && sel_tsel |=> timer_select_regs == $past(avs_writedata[7:0]))
      else $error("timer select write lost");
   en_write_a: assert property (wr_take && sel_en |=>
      capture_channel_irq_enable_hi == ($past(avs_writedata[7:0]) & en_mask))
      else $error("enable register write lost");
   od_write_a: assert property (wr_take && sel_od |=> open_drain_select_bits == $past(avs_writedata[7:2]))
      else $error("open-drain write lost");
   port_write_a: assert property (wr_take && sel_port |=> pin_direction_bit == $past(avs_writedata[1]))
      else $error("direction write lost");

   // Pin driver.
   od_low_a: assert property (!pin_direction_bit && !(od_this && port_latch_r) |=> cap_pin_oe)
      else $error("output pin not driven");
   oe_input_a: assert property (pin_direction_bit |=> !cap_pin_oe)
      else $error("input pin driven");

   // Covers mark the main scenarios: rising, falling and every-sixteenth captures, the port capture and the interrupt.
   cap_rise_c: cover property (ev_kind == CAPUN_EV_RISE && cap_evt);
   cap_fall_c: cover property (ev_kind == CAPUN_EV_FALL && cap_evt);
   cap_presc_c: cover property (capture_event_select == `CAPUN_M_RISE16 && cap_evt);
   cap_port_c: cover property (port_cap);
   irq_c: cover property (irq);
endmodule

// >>> src/capun_regs.svh
// Register offsets, field positions, reset values and encodings of the capture unit.
// Assumes Avalon-MM word addressing by byte address with 32-bit data.
`ifndef CAPUN_REGS_SVH
`define CAPUN_REGS_SVH

`define CAPUN_OFF_CTRL      8'h00
`define CAPUN_OFF_CAP_LOW   8'h04
`define CAPUN_OFF_CAP_HIGH  8'h08
`define CAPUN_OFF_FLAGS     8'h0C
`define CAPUN_OFF_IRQ_EN    8'h10
`define CAPUN_OFF_TMR_SEL   8'h14
`define CAPUN_OFF_OD_CTRL   8'h18
`define CAPUN_OFF_PORT      8'h1C
`define CAPUN_OFF_PIN_CFG   8'h20

`define CAPUN_FLAG_BIT      1
`define CAPUN_IRQEN_RST     8'h00
`define CAPUN_CTRL_RST      4'h0
`define CAPUN_OD_RST        6'h00
`define CAPUN_REMAP_RST     1'b1
`define CAPUN_PIN_CFG_RST   2'h3

`define CAPUN_M_FALL        4'h4
`define CAPUN_M_RISE        4'h5
`define CAPUN_M_RISE4       4'h6
`define CAPUN_M_RISE16      4'h7

`define CAPUN_PRESC4_TOP    4'h3
`define CAPUN_PRESC16_TOP   4'hF

`endif

// >>> src/capun_pkg.sv
// Types shared by the capture unit.
// Assumes the register header is included by users of offsets.
package capun_pkg;
   typedef enum logic [1:0] {
      CAPUN_EV_NONE,
      CAPUN_EV_FALL,
      CAPUN_EV_RISE,
      CAPUN_EV_PRESC
   } capun_ev_t;
endpackage

// >>> verif/capun_pin_src.sv
// Pin source model: an outside signal that drives the capture pin.
// Assumes its task is called just after a rising clock edge.
`timescale 1ns/1ps
module capun_pin_src (
   input  wire logic clock,
   output logic      pin
);
   initial pin = 1'h0;
   // Each level holds a stated number of cycles, so the synchroniser sees every one of them.
   task automatic drive(input logic v, input int gap);
      pin <= v;
      repeat (gap) @(posedge clock);
   endtask
endmodule

// >>> verif/capture_unit_with_pin_options_tb_top.sv
// Bench for the capture unit: bus tasks, capture scenarios and the verdict.
// Assumes the design, its header and the pin source model are compiled first.
`timescale 1ns/1ps
`include "capun_regs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module capture_unit_with_pin_options_tb_top;
   import capun_pkg::*;
   logic        clock = 1'h0, srst = 1'h1, avs_read = 1'h0, avs_write = 1'h0, remap_strap = 1'h1;
   logic [7:0]  avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, sm_rdata, rd, sm_rd;
   logic [15:0] timer_one_count = 16'h0, timer_three_count = 16'h0;
   logic        avs_waitrequest, sm_wait, src_pin, cap_pin_in, cap_pin_out, cap_pin_oe, remap_group_a, irq;
   logic [5:0]  open_drain_select_bits;
   int          errors = 0, n_compared = 0, cycles = 0;
   always #4 clock = ~clock;
   // The design's driver wins the wire whenever its enable is high.
   assign cap_pin_in = cap_pin_oe ? cap_pin_out : src_pin;
   capun_pin_src src_inst (.clock(clock), .pin(src_pin));
   capun_top #(.SMALL_MEM(1'h0)) capun_top_inst (.clock(clock), .srst(srst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .timer_one_count(timer_one_count), .timer_three_count(timer_three_count),
      .cap_pin_in(cap_pin_in), .cap_pin_out(cap_pin_out), .cap_pin_oe(cap_pin_oe), .remap_strap(remap_strap),
      .remap_group_a(remap_group_a), .open_drain_select_bits(open_drain_select_bits), .irq(irq));
   capun_top #(.SMALL_MEM(1'h1)) capun_top_small_inst (.clock(clock), .srst(srst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(sm_rdata),
      .avs_waitrequest(sm_wait), .timer_one_count(timer_one_count), .timer_three_count(timer_three_count),
      .cap_pin_in(src_pin), .cap_pin_out(), .cap_pin_oe(), .remap_strap(remap_strap), .remap_group_a(),
      .open_drain_select_bits(), .irq());
   task automatic finish_test();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         finish_test();
      end
   end
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= ~wr;
      do @(posedge clock); while (avs_waitrequest !== 1'h0);
      rd = avs_readdata;
      sm_rd = sm_rdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
      @(posedge clock);
   endtask
   function automatic int rises_needed(input logic [3:0] md);
      rises_needed = (md == `CAPUN_M_RISE16) ? 16 : (md == `CAPUN_M_RISE4) ? 4 : 1;
   endfunction
   task automatic reset();
      srst <= 1'h1;
      repeat (5) @(posedge clock);
      srst <= 1'h0;
      repeat (3) @(posedge clock);
   endtask
   task automatic pulse(input int n);
      repeat (n) begin
         src_inst.drive(1'h1, 2 + $urandom % 4);
         src_inst.drive(1'h0, 2 + $urandom % 4);
      end
      repeat (6) @(posedge clock);
   endtask
   task automatic flag_is(input logic f);
      bus(1'h0, `CAPUN_OFF_FLAGS, 32'h0);
      `CHK("flag", f, rd[`CAPUN_FLAG_BIT])
   endtask
   task automatic cap_check(input logic [15:0] e);
      bus(1'h0, `CAPUN_OFF_CAP_LOW, 32'h0);
      `CHK("cap_low", e[7:0], rd[7:0])
      bus(1'h0, `CAPUN_OFF_CAP_HIGH, 32'h0);
      `CHK("cap_high", e[15:8], rd[7:0])
   endtask
   initial begin
      logic [15:0] t1, t3;
      logic [3:0]  m;
      logic        s;
      int          need;
      void'($urandom(32'h5C0D3E37));
      reset();
      bus(1'h0, `CAPUN_OFF_IRQ_EN, 32'h0);
      `CHK("irq_en_rst", `CAPUN_IRQEN_RST, rd[7:0])
      bus(1'h0, `CAPUN_OFF_PIN_CFG, 32'h0);
      `CHK("pin_cfg", `CAPUN_PIN_CFG_RST, rd[1:0])
      `CHK("group_a", 1'h1, remap_group_a)
      bus(1'h0, 8'hFC, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      bus(1'h1, `CAPUN_OFF_IRQ_EN, 32'hFF);
      bus(1'h0, `CAPUN_OFF_IRQ_EN, 32'h0);
      `CHK("irq_en", 8'hFF, rd[7:0])
      `CHK("irq_en_small", 8'h3F, sm_rd[7:0])
      $display("registers done");
      for (int i = 4; i < 8; i++) begin
         m = 4'(i);
         need = rises_needed(m);
         t1 = 16'($urandom);
         t3 = 16'($urandom);
         s = 1'($urandom);
         timer_one_count <= t1;
         timer_three_count <= t3;
         bus(1'h1, `CAPUN_OFF_TMR_SEL, {31'h0, s});
         bus(1'h1, `CAPUN_OFF_CTRL, 32'h0);
         bus(1'h1, `CAPUN_OFF_FLAGS, 32'h2);
         pulse(1);
         flag_is(1'h0);
         bus(1'h1, `CAPUN_OFF_CTRL, {28'h0, m});
         pulse(need - 1);
         flag_is(1'h0);
         src_inst.drive(1'h1, 6);
         flag_is(m != `CAPUN_M_FALL);
         src_inst.drive(1'h0, 6);
         flag_is(1'h1);
         `CHK("irq", 1'h1, irq)
         cap_check(s ? t3 : t1);
      end
      $display("modes done");
      bus(1'h1, `CAPUN_OFF_CTRL, {28'h0, `CAPUN_M_RISE});
      bus(1'h1, `CAPUN_OFF_TMR_SEL, 32'h0);
      timer_one_count <= ~t1;
      pulse(1);
      timer_one_count <= t1;
      pulse(1);
      cap_check(t1);
      bus(1'h1, `CAPUN_OFF_FLAGS, 32'h0);
      flag_is(1'h1);
      bus(1'h1, `CAPUN_OFF_FLAGS, 32'h2);
      flag_is(1'h0);
      `CHK("irq_clr", 1'h0, irq)
      $display("overwrite and clear done");
      bus(1'h1, `CAPUN_OFF_IRQ_EN, 32'h0);
      bus(1'h1, `CAPUN_OFF_CTRL, 32'h0);
      bus(1'h1, `CAPUN_OFF_PORT, 32'h0);
      flag_is(1'h0);
      timer_one_count <= t1 + 16'h1;
      bus(1'h1, `CAPUN_OFF_PORT, 32'h1);
      repeat (2) @(posedge clock);
      `CHK("pin_oe", 1'h1, cap_pin_oe)
      `CHK("pin_out", 1'h1, cap_pin_out)
      flag_is(1'h1);
      `CHK("irq_masked", 1'h0, irq)
      cap_check(t1 + 16'h1);
      bus(1'h1, `CAPUN_OFF_PORT, 32'h2);
      t3 = 16'($urandom);
      bus(1'h1, `CAPUN_OFF_OD_CTRL, {24'h0, t3[7:0]});
      @(posedge clock);
      `CHK("od_bits", t3[7:2], open_drain_select_bits)
      bus(1'h1, `CAPUN_OFF_OD_CTRL, 32'h4);
      bus(1'h1, `CAPUN_OFF_PORT, 32'h1);
      repeat (2) @(posedge clock);
      `CHK("od_high_oe", 1'h0, cap_pin_oe)
      bus(1'h1, `CAPUN_OFF_PORT, 32'h0);
      repeat (2) @(posedge clock);
      `CHK("od_low_oe", 1'h1, cap_pin_oe)
      `CHK("od_low_out", 1'h0, cap_pin_out)
      bus(1'h1, `CAPUN_OFF_PORT, 32'h2);
      $display("port and open drain done");
      remap_strap <= 1'h0;
      reset();
      `CHK("group_alt", 1'h0, remap_group_a)
      bus(1'h0, `CAPUN_OFF_PIN_CFG, 32'h0);
      `CHK("pin_cfg_alt", 2'h1, rd[1:0])
      $display("strap done");
      finish_test();
   end
endmodule
